//--- src/tirq_pkg.sv
package tirq_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_MASK = 12'h0_018;
  localparam logic [11:0] OFS_RAW = 12'h0_01C;
  localparam logic [11:0] OFS_MIS = 12'h0_020;
  localparam logic [11:0] OFS_ICR = 12'h0_024;
  localparam logic [11:0] OFS_TAILR = 12'h0_028;
  localparam logic [11:0] OFS_TBILR = 12'h0_02C;
  localparam logic [11:0] OFS_CFG = 12'h0_000;

  // ---------------------------------------------------------------
  // event field positions
  // ---------------------------------------------------------------
  localparam int BIT_TMRA_TO = 0;
  localparam int BIT_CAPA_MATCH = 1;
  localparam int BIT_CAPA_EVENT = 2;
  localparam int BIT_CLOCK_EVENT = 3;
  localparam int BIT_TMRB_TO = 8;
  localparam int BIT_CAPB_MATCH = 9;
  localparam int BIT_CAPB_EVENT = 10;
  localparam logic [10:0] EVT_VALID = 11'h7_0F;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] LOAD_RST = 16'hFFFF;
  localparam logic [15:0] LOAD_UPPER_16_RST = 16'h0000;
  localparam logic [10:0] IRQ_RST = 11'h0_00;
  localparam logic CFG_RST = 1'b0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // one register-bus request as seen by the register file
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] waddr;
    logic [11:0] raddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } tirq_req_t;

  // bus states, gray along idle -> resp
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RESP = 2'b01
  } tirq_st_t;

endpackage

//--- src/tirq_axil.sv
`timescale 1ns/1ps
`default_nettype none
module tirq_axil (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output tirq_pkg::tirq_req_t req,
  input wire logic [31:0] rdata,
  input wire logic rerr,
  input wire logic werr
);
  import tirq_pkg::*;

  typedef struct packed {
    logic aw_ok;
    logic w_ok;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    tirq_st_t wst;
    tirq_st_t rst_st;
    logic [1:0] bresp;
    logic [31:0] rdat;
    logic [1:0] rresp;
  } tirq_axs_t;

  tirq_axs_t s_q, s_d;
  logic do_wr, do_rd;

  // ---------------------------------------------------------------
  // channel acceptance and response
  // ---------------------------------------------------------------
  assign do_wr = s_q.aw_ok && s_q.w_ok && s_q.wst == ST_IDLE;
  assign do_rd = s_arvalid && s_q.rst_st == ST_IDLE;

  // one request per cycle to the register file
  always_comb begin
    req.wr = do_wr;
    req.rd = do_rd;
    req.waddr = s_q.awaddr;
    req.raddr = s_araddr;
    req.wdata = s_q.wdata;
    req.wstrb = s_q.wstrb;
  end

  // next state of the slave
  always_comb begin
    s_d = s_q;
    if (s_awvalid && !s_q.aw_ok && s_q.wst == ST_IDLE) begin
      s_d.aw_ok = 1'b1;
      s_d.awaddr = s_awaddr;
    end
    if (s_wvalid && !s_q.w_ok && s_q.wst == ST_IDLE) begin
      s_d.w_ok = 1'b1;
      s_d.wdata = s_wdata;
      s_d.wstrb = s_wstrb;
    end
    if (do_wr) begin
      s_d.aw_ok = 1'b0;
      s_d.w_ok = 1'b0;
      s_d.wst = ST_RESP;
      s_d.bresp = werr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_q.wst == ST_RESP && s_bready) begin
      s_d.wst = ST_IDLE;
    end
    if (do_rd) begin
      s_d.rst_st = ST_RESP;
      s_d.rdat = rdata;
      s_d.rresp = rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_q.rst_st == ST_RESP && s_rready) begin
      s_d.rst_st = ST_IDLE;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{aw_ok: 1'b0, w_ok: 1'b0, awaddr: '0, wdata: '0, wstrb: '0,
               wst: ST_IDLE, rst_st: ST_IDLE, bresp: RESP_OKAY,
               rdat: '0, rresp: RESP_OKAY};
    end else begin
      s_q <= s_d;
    end
  end

  assign s_awready = !s_q.aw_ok && s_q.wst == ST_IDLE;
  assign s_wready = !s_q.w_ok && s_q.wst == ST_IDLE;
  assign s_bvalid = s_q.wst == ST_RESP;
  assign s_bresp = s_q.bresp;
  assign s_arready = s_q.rst_st == ST_IDLE;
  assign s_rvalid = s_q.rst_st == ST_RESP;
  assign s_rdata = s_q.rdat;
  assign s_rresp = s_q.rresp;

endmodule
`default_nettype wire

//--- src/tirq_top.sv
// Behaviour
// - masked bit set only if unmasked and occurred
// - timer B side masked bits at 10..8
// - timer A side masked bits at 3..0
// - reserved bits unchanged; read as zero
// - written one clears raw and masked bit
// - written zero leaves status alone
// - clear bits share status bit positions
// - 32-bit mode: upper half is timer B load
// - 16-bit mode: upper reads zero, writes ignored
// - 32-bit upper write loads timer B load
// - lower write loads timer A, reads back
// - reset: lower ones, upper per width mode
// - raw bits set regardless of mask
// - mask one enables, zero disables interrupt
`timescale 1ns/1ps
`default_nettype none
module tirq_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic [10:0] event_in,
  output logic irq,
  output logic tmra_load_pulse,
  output logic tmrb_load_pulse,
  output logic [15:0] tmra_load_value,
  output logic [15:0] tmrb_load_value,
  output logic wide_mode
);
  import tirq_pkg::*;

  typedef struct packed {
    logic [10:0] raw;
    logic [10:0] mask;
    logic [15:0] load_lower_half;
    logic [15:0] tmrb_load;
    logic wide;
    logic irq;
    logic a_pulse;
    logic b_pulse;
  } tirq_state_t;

  tirq_state_t s_q, s_d;
  tirq_req_t req;
  logic [31:0] rdata;
  logic rerr, werr;

  // byte-lane merge of a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0] be);
    merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  // known-address check
  function automatic logic known(input logic [11:0] a);
    known = a == OFS_MASK || a == OFS_RAW || a == OFS_MIS ||
            a == OFS_ICR || a == OFS_TAILR || a == OFS_TBILR ||
            a == OFS_CFG;
  endfunction

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  tirq_axil u_axil (
    .clk(clk),
    .rst(rst),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .req(req),
    .rdata(rdata),
    .rerr(rerr),
    .werr(werr)
  );

  assign rerr = !known(req.raddr);
  assign werr = !known(req.waddr);

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rdata = 32'h0000_0000;
    if (req.raddr == OFS_MASK) begin
      rdata = {21'h0, s_q.mask & EVT_VALID};
    end else if (req.raddr == OFS_RAW) begin
      rdata = {21'h0, s_q.raw};
    end else if (req.raddr == OFS_MIS) begin
      rdata = {21'h0, s_q.raw & s_q.mask};
    end else if (req.raddr == OFS_TAILR) begin
      // upper half aliases timer B load only when wide
      rdata = {s_q.wide ? s_q.tmrb_load : 16'h0000,
               s_q.load_lower_half};
    end else if (req.raddr == OFS_TBILR) begin
      rdata = {16'h0000, s_q.tmrb_load};
    end else if (req.raddr == OFS_CFG) begin
      rdata = {31'h0, s_q.wide};
    end
  end

  // ---------------------------------------------------------------
  // register file and status update
  // ---------------------------------------------------------------
  always_comb begin
    logic [10:0] clr;
    logic [15:0] mask16;
    clr = 11'h0_00;
    mask16 = merge16({5'h0, s_q.mask}, req.wdata[15:0], req.wstrb[1:0]);
    s_d = s_q;
    s_d.a_pulse = 1'b0;
    s_d.b_pulse = 1'b0;
    if (req.wr) begin
      if (req.waddr == OFS_MASK) begin
        // one enables, zero disables; reserved kept zero
        s_d.mask = mask16[10:0] & EVT_VALID;
      end else if (req.waddr == OFS_ICR) begin
        // only written ones clear, same positions as status
        clr = {req.wstrb[1] ? req.wdata[10:8] : 3'h0,
               4'h0,
               req.wstrb[0] ? req.wdata[3:0] : 4'h0};
      end else if (req.waddr == OFS_TAILR) begin
        if (req.wstrb[1:0] != 2'b00) begin
          s_d.load_lower_half = merge16(s_q.load_lower_half,
                                        req.wdata[15:0],
                                        req.wstrb[1:0]);
          s_d.a_pulse = 1'b1;
        end
        if (s_q.wide && req.wstrb[3:2] != 2'b00) begin
          s_d.tmrb_load = merge16(s_q.tmrb_load, req.wdata[31:16],
                                  req.wstrb[3:2]);
          s_d.b_pulse = 1'b1;
        end
      end else if (req.waddr == OFS_TBILR) begin
        // direct timer B load ignored in wide mode
        if (!s_q.wide && req.wstrb[1:0] != 2'b00) begin
          s_d.tmrb_load = merge16(s_q.tmrb_load, req.wdata[15:0],
                                  req.wstrb[1:0]);
          s_d.b_pulse = 1'b1;
        end
      end else if (req.waddr == OFS_CFG && req.wstrb[0]) begin
        s_d.wide = req.wdata[0];
        // switching width reloads the upper half per its reset rule
        if (req.wdata[0] != s_q.wide) begin
          s_d.tmrb_load = req.wdata[0] ? LOAD_RST : LOAD_UPPER_16_RST;
        end
      end
    end
    // events set raw bits whatever the mask; set wins over clear
    s_d.raw = ((s_q.raw & ~clr) | event_in) & EVT_VALID;
    s_d.irq = |(s_d.raw & s_d.mask);
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{raw: IRQ_RST, mask: IRQ_RST, load_lower_half: LOAD_RST,
               tmrb_load: LOAD_UPPER_16_RST, wide: CFG_RST, irq: 1'b0,
               a_pulse: 1'b0, b_pulse: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign irq = s_q.irq;
  assign tmra_load_pulse = s_q.a_pulse;
  assign tmrb_load_pulse = s_q.b_pulse;
  assign tmra_load_value = s_q.load_lower_half;
  assign tmrb_load_value = s_q.tmrb_load;
  assign wide_mode = s_q.wide;

endmodule
`default_nettype wire

//--- test/tirq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tirq_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic [10:0] event_in,
  input wire logic irq,
  input wire logic tmra_load_pulse,
  input wire logic [15:0] tmra_load_value,
  input wire logic [15:0] tmrb_load_value,
  input wire logic wide_mode
);
  import tirq_pkg::*;
  // -------------------------------
  // bus answers and status causes
  // -------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // address and data handed over at one edge
  sequence wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  // a write answer is showing or has just shown
  sequence wr_near;
    s_bvalid || $past(s_bvalid);
  endsequence
  chk_write_answer: assert property (wr_taken |-> ##[1:2] s_bvalid)
    else $error("write answer missing");
  chk_read_answer: assert property (
    s_arvalid && s_arready |-> ##[1:2] s_rvalid)
    else $error("read answer missing");
  chk_resp_holds: assert property (
    s_bvalid && !s_bready |=> s_bvalid)
    else $error("write answer dropped early");
  chk_irq_rise: assert property (
    $rose(irq) && !$past(|(event_in & EVT_VALID)) |-> wr_near)
    else $error("irq rose without event or write");
  chk_irq_fall: assert property ($fell(irq) |-> wr_near)
    else $error("irq fell without a write");
  chk_load_a: assert property (
    $changed(tmra_load_value) || tmra_load_pulse |-> wr_near)
    else $error("timer a load moved without a write");
  chk_load_b: assert property (
    $changed(tmrb_load_value) && !$changed(wide_mode) |-> wr_near)
    else $error("timer b load moved without a write");
  chk_wide_upper: assert property (
    $rose(wide_mode) |-> ##[0:1] tmrb_load_value == 16'hFFFF)
    else $error("upper load not ones in wide mode");
  chk_narrow_upper: assert property (
    $fell(wide_mode) |-> ##[0:1] tmrb_load_value == 16'h0000)
    else $error("upper load not zero in narrow mode");
  chk_mode_write: assert property ($changed(wide_mode) |-> wr_near)
    else $error("width mode moved without a write");
endmodule
bind tirq_top tirq_properties u_tirq_properties (.clk(clk), .rst(rst),
  .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid),
  .s_wready(s_wready), .s_bvalid(s_bvalid), .s_bready(s_bready),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
  .event_in(event_in), .irq(irq), .tmra_load_pulse(tmra_load_pulse),
  .tmra_load_value(tmra_load_value), .tmrb_load_value(tmrb_load_value),
  .wide_mode(wide_mode));
`default_nettype wire

//--- test/test_tirq_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_tirq_top;
  import tirq_pkg::*;
  logic clk, rst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
  logic s_bready, s_arvalid, s_arready, s_rvalid, s_rready, irq, wide_mode;
  logic tmra_load_pulse, tmrb_load_pulse;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rv, e;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rr, lp;
  logic [10:0] event_in;
  logic [15:0] tmra_load_value, tmrb_load_value;
  int miscompares, compares, cyc;

  tirq_top u_tirq_top (.clk, .rst, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
    .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready, .event_in, .irq, .tmra_load_pulse,
    .tmrb_load_pulse, .tmra_load_value, .tmrb_load_value, .wide_mode);

  // free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      results();
    end
  end

  // -------------------------------
  // bus tasks and comparison
  // -------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_awvalid && s_awready) aw = 1'b1;
      if (s_wvalid && s_wready) w = 1'b1;
      if (aw) s_awvalid <= 1'b0;
      if (w) s_wvalid <= 1'b0;
    end
    do @(posedge clk); while (s_bvalid !== 1'b1);
    rr = s_bresp;
    // load pulses stand in the cycle that ends with the answer
    lp = {tmrb_load_pulse, tmra_load_pulse};
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge clk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    while (s_rvalid !== 1'b1) @(posedge clk);
    rv = s_rdata;
    rr = s_rresp;
    s_rready <= 1'b0;
  endtask

  // read one register and compare data and response
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    check(rv, exp);
    check({30'h0, rr}, {30'h0, RESP_OKAY});
  endtask

  // one cycle event strobe
  task automatic ev(input logic [10:0] v);
    @(posedge clk);
    event_in <= v;
    @(posedge clk);
    event_in <= '0;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    s_awaddr = '0;
    s_araddr = '0;
    s_wdata = '0;
    s_wstrb = 4'hF;
    event_in = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rchk(OFS_TAILR, 32'h0000_FFFF);
    rchk(OFS_MIS, 32'h0000_0000);
    check({16'h0, tmrb_load_value}, 32'h0000_0000);
    $display("test reset done");
    ev(11'h7FF);
    rchk(OFS_RAW, 32'h0000_070F);
    rchk(OFS_MIS, 32'h0000_0000);
    check({31'h0, irq}, 32'h0);
    wr(OFS_MASK, 32'h0000_060E);
    rchk(OFS_MIS, 32'h0000_060E);
    check({31'h0, irq}, 32'h1);
    wr(OFS_MASK, 32'h0000_070F);
    rchk(OFS_MIS, 32'h0000_070F);
    wr(OFS_ICR, 32'h0000_0000);
    rchk(OFS_MIS, 32'h0000_070F);
    rchk(OFS_ICR, 32'h0000_0000);
    e = 32'h0000_070F;
    for (int i = 0; i < 11; i++) begin
      if (EVT_VALID[i]) begin
        e[i] = 1'b0;
        wr(OFS_ICR, 32'h1 << i);
        rchk(OFS_MIS, e);
        rchk(OFS_RAW, e);
      end
    end
    check({31'h0, irq}, 32'h0);
    wr(OFS_MASK, 32'h0000_0000);
    // event and clear land on one edge: the event wins
    fork
      wr(OFS_ICR, 32'h0000_0001);
      begin
        repeat (2) @(posedge clk);
        event_in <= 11'h001;
        @(posedge clk);
        event_in <= '0;
      end
    join
    rchk(OFS_RAW, 32'h0000_0001);
    rchk(OFS_MIS, 32'h0000_0000);
    check({31'h0, irq}, 32'h0);
    wr(OFS_MASK, 32'h0000_0001);
    check({31'h0, irq}, 32'h1);
    wr(OFS_ICR, 32'h0000_0001);
    check({31'h0, irq}, 32'h0);
    $display("test status done");
    wr(OFS_TAILR, 32'h1234_5678);
    check({30'h0, lp}, 32'h1);
    rchk(OFS_TAILR, 32'h0000_5678);
    check({tmrb_load_value, tmra_load_value}, 32'h0000_5678);
    wr(OFS_CFG, 32'h0000_0001);
    check({31'h0, wide_mode}, 32'h1);
    rchk(OFS_TAILR, 32'hFFFF_5678);
    wr(OFS_TAILR, 32'hABCD_0123);
    check({30'h0, lp}, 32'h3);
    rchk(OFS_TAILR, 32'hABCD_0123);
    check({16'h0, tmrb_load_value}, 32'h0000_ABCD);
    rchk(OFS_TBILR, 32'h0000_ABCD);
    wr(OFS_TBILR, 32'h0000_0077);
    check({30'h0, lp}, 32'h0);
    rchk(OFS_TBILR, 32'h0000_ABCD);
    wr(OFS_CFG, 32'h0000_0000);
    check({31'h0, wide_mode}, 32'h0);
    rchk(OFS_TAILR, 32'h0000_0123);
    wr(OFS_TAILR, 32'h5555_0042);
    check({30'h0, lp}, 32'h1);
    rchk(OFS_TBILR, 32'h0000_0000);
    wr(OFS_TBILR, 32'h0000_0077);
    check({30'h0, lp}, 32'h2);
    rchk(OFS_TAILR, 32'h0000_0042);
    $display("test load done");
    wr(12'h1_00, 32'h0000_0001);
    check({30'h0, rr}, {30'h0, RESP_SLVERR});
    rd(12'h1_00);
    check({30'h0, rr}, {30'h0, RESP_SLVERR});
    check(rv, 32'h0000_0000);
    $display("test unmapped done");
    results();
  end
endmodule
`default_nettype wire
